//--- nhs_sequencer.sv
/*
 * neural engine host sequencer: run handshake, input memory writes,
 * byte reduction into the scratch pad and expansion onto the result
 * port, plus an apb register slave. assumes a host on the same clock.
 */
// Behaviour
// RULE1: asserting reset returns every output to its default next cycle.
// RULE2: engine_idle defaults to one, all other outputs to zero; apb pready is tied high instead.
// RULE3: a reset held for a single clock cycle is a complete reset.
// RULE4: host keeps run_request low at reset release, loads commands first.
// RULE5: host writes inputs only after seeing engine_idle high.
// RULE6: run_request high makes engine_idle fall; host then drops run_request.
// RULE7: host captures result_word each cycle result_valid is high.
// RULE8: command words are 32 bit, little endian, based at address zero.
// RULE9: input port is 16 bit; byte modes use low byte only; the reduction here takes the whole 16-bit word.
// RULE10: inputs go to network-mapped addresses, read little endian.
// RULE11: results are a programmed count of 16-bit words, lowest first.
// RULE12: build option picks convolutional or binary engine; convolutional default.
// RULE13: working memory 8, 32, 64, 96 or 128 kB; large two for binary.
// RULE14: binary engine encodes values as +1/-1 or +1/0, default +1/0.
// RULE15: convolutional byte modes allow one, two or four pointwise units.
// RULE16: scratch pad 1K, 2K or 4K two-byte entries; binary fixed 1K.
// RULE17: four pointwise units double the scratch pad with a second memory.
// RULE18: inputs are signed byte, unsigned byte or 16-bit only (default).
// RULE19: byte modes store results as bytes, expand to 16 bits on readout.
// RULE20: shift s 1..7 places byte with s sign or zero bits above.
// RULE21: shift zero puts byte over eight zeros; unsigned drops bit seven.
// RULE22: reduction gives 8'h00 for negative, 8'hff when saturated.
// RULE23: reset is active low and clears all ports and registers; count resets to 2, engine_idle and pready stay high, memories keep their contents.
// RULE24: input writes while engine_idle is low are ignored.
// RULE25: after the last result the engine goes idle and awaits run.
// RULE26: expansion is a combinational mux on shift and signedness.
`timescale 1ns/1ps
`include "nhs_cfg.svh"

module nhs_sequencer #(
   parameter nhs_pkg::nhs_engine_e ENGINE = nhs_pkg::NHS_CONV,
   parameter nhs_pkg::nhs_mem_e MEM_OPTION = nhs_pkg::NHS_TWO_LARGE,
   parameter nhs_pkg::nhs_binenc_e BIN_ENC = nhs_pkg::NHS_PLUS_ZERO,
   parameter int POINTWISE_UNITS = 1,
   parameter int SCRATCH_K = 1,
   parameter nhs_pkg::nhs_bytemode_e BYTE_MODE = nhs_pkg::NHS_WORD16,
   parameter logic [2:0] BYTE_SHIFT = 3'h5
) (
   input wire logic pclk, // system clock, 125 MHz
   input wire logic presetn, // asynchronous reset, active low
   input wire nhs_pkg::nhs_apb_req_s apb_req, // apb request
   output nhs_pkg::nhs_apb_rsp_s apb_rsp, // apb answer
   input wire logic run_request, // level run request from host
   output logic engine_idle, // high while ready for inputs
   input wire nhs_pkg::nhs_in_wr_s in_wr, // input memory write port
   output nhs_pkg::nhs_result_s result // result stream, no back-pressure
);
   import nhs_pkg::*;

   // ****************************************************************
   // build options resolved
   // ****************************************************************
   // large three and four exist only for the convolutional engine;
   // a binary build asking for them falls back to two
   localparam nhs_mem_e MEM_EFF = (ENGINE == NHS_BINARY &&
      (MEM_OPTION == NHS_THREE_LARGE || MEM_OPTION == NHS_FOUR_LARGE)) ?
      NHS_TWO_LARGE : MEM_OPTION; // [RULE13] [RULE12]
   localparam int MEM_KB = (MEM_EFF == NHS_BLOCK_RAM) ? 8 :
      (MEM_EFF == NHS_ONE_LARGE) ? 32 : (MEM_EFF == NHS_TWO_LARGE) ? 64 :
      (MEM_EFF == NHS_THREE_LARGE) ? 96 : 128; // [RULE13]
   localparam int MEM_WORDS = MEM_KB * `NHS_KB_WORDS;
   // index width of the working memory; the largest option needs all
   // sixteen address bits, so wrap by slicing rather than by modulo
   localparam int MW = $clog2(MEM_WORDS);
   // the command image is laid down from word zero, little endian
   localparam logic [15:0] CMD_BASE = `NHS_CMD_BASE; // [RULE8]
   localparam bit BYTE_ON = (ENGINE == NHS_CONV) && (BYTE_MODE != NHS_WORD16);
   localparam int UNITS = (BYTE_ON && (POINTWISE_UNITS == 2 ||
      POINTWISE_UNITS == 4)) ? POINTWISE_UNITS : 1; // [RULE15]
   localparam int SP_BASE = (ENGINE == NHS_CONV) ?
      SCRATCH_K * `NHS_SCRATCH_UNIT : `NHS_SCRATCH_UNIT; // [RULE16]
   localparam int SP_BANKS = (UNITS == 4) ? 2 : 1; // [RULE17]
   localparam int SP_WORDS = SP_BASE * SP_BANKS;
   localparam int SPW = $clog2(SP_WORDS);
   localparam logic [16:0] SP_MAX = 17'(SP_WORDS);
   localparam bit SGN = (BYTE_MODE == NHS_SIGNED8); // [RULE18]

   // ****************************************************************
   // byte conversion
   // ****************************************************************
   function automatic logic [15:0] nhs_expand(input logic [7:0] b,
         input logic sgn, input logic [2:0] s);
      logic [15:0] ext;
      logic [3:0] sh;
      ext = sgn ? {{8{b[7]}}, b} : {8'h00, b};
      sh = 4'h8 - {1'b0, s};
      case (s) // [RULE26]
         3'h0: nhs_expand = sgn ? {b, 8'h00} :
            {1'b0, b[6:0], 8'h00}; // [RULE21]
         default: nhs_expand = ext << sh; // [RULE20]
      endcase
   endfunction : nhs_expand

   function automatic logic [7:0] nhs_reduce(input logic [15:0] v,
         input logic sgn, input logic [2:0] s);
      logic [15:0] shifted;
      logic [3:0] sh;
      sh = 4'h8 - {1'b0, s};
      shifted = v >> sh;
      if (v[15]) begin
         nhs_reduce = 8'h00; // [RULE22]
      end else if (|shifted[15:8]) begin
         nhs_reduce = 8'hff; // [RULE22]
      end else if (!sgn && s == 3'h0 && shifted[7]) begin
         nhs_reduce = 8'h7f; // unsigned zero shift only keeps seven bits
      end else begin
         nhs_reduce = shifted[7:0];
      end
   endfunction : nhs_reduce

   // ****************************************************************
   // state and memories
   // ****************************************************************
   nhs_state_e state_q;
   logic [15:0] work_mem [MEM_WORDS];
   logic [15:0] scratch [SP_WORDS];
   logic [15:0] count_q;
   logic [15:0] base_q;
   logic [16:0] idx_q;
   logic [15:0] done_q;
   logic [31:0] cycles_q;
   logic [16:0] limit;
   logic start;
   logic in_accept;
   logic [15:0] sp_rd;

   // results never exceed what the scratch pad holds
   assign limit = ({1'b0, count_q} > SP_MAX) ? SP_MAX : {1'b0, count_q};
   assign start = (state_q == NHS_S_IDLE) && run_request; // [RULE6]
   assign in_accept = in_wr.we && (state_q == NHS_S_IDLE); // [RULE24]
   assign engine_idle = (state_q == NHS_S_IDLE); // [RULE2]
   assign sp_rd = scratch[idx_q[SPW-1:0]];

   always_ff @(posedge pclk) begin
      if (in_accept) begin
         work_mem[in_wr.addr[MW-1:0]] <= in_wr.data; // [RULE10]
      end
   end

   // ****************************************************************
   // sequencing
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= NHS_S_IDLE; // [RULE1] [RULE3] [RULE23]
      end else begin
         case (state_q)
            NHS_S_IDLE: begin
               if (start) begin
                  state_q <= (limit == 17'h0) ? NHS_S_EMIT : NHS_S_REDUCE;
               end
            end
            NHS_S_REDUCE: begin
               if (idx_q + 17'(UNITS) >= limit) begin
                  state_q <= NHS_S_EMIT;
               end
            end
            NHS_S_EMIT: begin
               if (idx_q + 17'h1 >= limit) begin
                  state_q <= NHS_S_IDLE; // [RULE25]
               end
            end
            default: state_q <= NHS_S_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idx_q <= 17'h0;
      end else if (start) begin
         idx_q <= 17'h0;
      end else if (state_q == NHS_S_REDUCE) begin
         idx_q <= (idx_q + 17'(UNITS) >= limit) ? 17'h0 :
            idx_q + 17'(UNITS);
      end else if (state_q == NHS_S_EMIT) begin
         idx_q <= idx_q + 17'h1;
      end
   end

   // each pointwise unit reduces one word per cycle into its lane
   for (genvar u = 0; u < UNITS; u++) begin : g_unit
      logic [16:0] pos;
      logic [15:0] src;
      logic [15:0] stored;
      logic [15:0] rd_addr;
      assign pos = idx_q + 17'(u);
      // the sum wraps at sixteen bits, then at the memory depth
      assign rd_addr = base_q + pos[15:0];
      assign src = work_mem[rd_addr[MW-1:0]];
      always_comb begin
         if (ENGINE == NHS_BINARY) begin
            stored = !src[15] ? 16'h0001 :
               (BIN_ENC == NHS_PLUS_MINUS ? 16'hffff : 16'h0000); // [RULE14]
         end else if (BYTE_ON) begin
            stored = {8'h00, nhs_reduce(src, SGN, BYTE_SHIFT)}; // [RULE19]
         end else begin
            stored = src;
         end
      end
      always_ff @(posedge pclk) begin
         if (state_q == NHS_S_REDUCE && pos < limit) begin
            scratch[pos[SPW-1:0]] <= stored;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result <= '0; // [RULE1] [RULE2]
      end else begin
         result.valid <= (state_q == NHS_S_EMIT) && (idx_q < limit); // [RULE11]
         result.word <= !(state_q == NHS_S_EMIT && idx_q < limit) ? 16'h0 :
            BYTE_ON ? nhs_expand(sp_rd[7:0], SGN, BYTE_SHIFT) : sp_rd; // [RULE19]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_q <= 16'h0;
         cycles_q <= 32'h0;
      end else if (start) begin
         done_q <= 16'h0;
         cycles_q <= 32'h0;
      end else if (state_q != NHS_S_IDLE) begin
         cycles_q <= cycles_q + 32'h1;
         if (state_q == NHS_S_EMIT && idx_q < limit) begin
            done_q <= done_q + 16'h1;
         end
      end
   end

   // ****************************************************************
   // apb register slave
   // ****************************************************************
   logic wr_en;
   logic setup;
   logic mapped;
   logic [31:0] prdata_q;
   logic pslverr_q;
   assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign setup = apb_req.psel && !apb_req.penable;
   assign mapped = apb_req.paddr == `NHS_OFS_COUNT ||
      apb_req.paddr == `NHS_OFS_BASE || apb_req.paddr == `NHS_OFS_STATUS ||
      apb_req.paddr == `NHS_OFS_CYCLES;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q <= `NHS_RST_COUNT;
         base_q <= `NHS_RST_BASE;
      end else if (wr_en && apb_req.paddr == `NHS_OFS_COUNT) begin
         count_q <= apb_req.pwdata[15:0]; // [RULE11]
      end else if (wr_en && apb_req.paddr == `NHS_OFS_BASE) begin
         base_q <= apb_req.pwdata[15:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0;
         pslverr_q <= 1'b0;
      end else if (setup) begin
         pslverr_q <= !mapped;
         case (apb_req.paddr)
            `NHS_OFS_COUNT: prdata_q <= {16'h0, count_q};
            `NHS_OFS_BASE: prdata_q <= {16'h0, base_q};
            `NHS_OFS_STATUS: prdata_q <= {done_q, 13'h0,
               state_q == NHS_S_EMIT, state_q == NHS_S_REDUCE, engine_idle};
            `NHS_OFS_CYCLES: prdata_q <= cycles_q;
            default: prdata_q <= 32'h0;
         endcase
      end
   end
   // zero wait states: every access phase completes at its first edge;
   // the answer is one packed word, so it gets exactly one driver
   assign apb_rsp = '{pready: 1'b1, pslverr: pslverr_q, prdata: prdata_q};

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_run_drops_idle: assert property (start |=> !engine_idle) // [RULE6]
      else $error("engine_idle did not fall after run request");
   a_idle_no_result: assert property (engine_idle |-> ##1 1'b1 ##0
      $past(engine_idle) && $past(engine_idle, 2) |-> !result.valid) // [RULE7]
      else $error("result emitted while idle");
   a_wr_ignored: assert property (in_wr.we && !engine_idle |-> !in_accept)
      // [RULE24]
      else $error("input write accepted while busy");
   a_emit_finish: assert property (state_q == NHS_S_EMIT &&
      idx_q + 17'h1 >= limit |=> engine_idle) // [RULE25]
      else $error("engine did not return idle after last result");
   a_result_count: assert property ($rose(engine_idle) |->
      ##1 done_q == 16'(limit)) // [RULE11]
      else $error("wrong number of results emitted");
   a_word_expand: assert property (BYTE_ON && result.valid |->
      result.word[7-BYTE_SHIFT:0] == '0) // [RULE20]
      else $error("expanded result has nonzero low bits");
   a_reduce_sat: assert property (nhs_reduce(16'h8000, SGN, BYTE_SHIFT)
      == 8'h00 && nhs_reduce(16'h7fff, SGN, 3'h5) == 8'hff) // [RULE22]
      else $error("reduction of extreme values wrong");
   a_zero_shift: assert property (nhs_expand(8'h81, 1'b0, 3'h0) == 16'h0100
      && nhs_expand(8'h81, 1'b1, 3'h0) == 16'h8100) // [RULE21]
      else $error("zero shift expansion wrong");
   a_binary_vals: assert property (ENGINE == NHS_BINARY && result.valid |->
      result.word == 16'h0001 || result.word == (BIN_ENC == NHS_PLUS_MINUS ?
      16'hffff : 16'h0000)) // [RULE14]
      else $error("binary engine emitted a non-binary value");
   a_valid_burst: assert property ($rose(result.valid) && limit > 17'h1
      |=> result.valid) // [RULE11]
      else $error("result burst broken");
   a_reset_idle: assert property ($rose(presetn) |-> engine_idle &&
      !result.valid) // [RULE1]
      else $error("outputs not at default after reset");
   // a quiet result port keeps its data at zero, its default value
   a_result_quiet: assert property (!result.valid |->
      result.word == 16'h0) // [RULE2]
      else $error("result word nonzero while not valid");
   a_busy_not_idle: assert property (state_q != NHS_S_IDLE |->
      !engine_idle) // [RULE6]
      else $error("engine_idle high while busy");

   c_run_start: cover property (start);
   c_burst_done: cover property (result.valid ##1 !result.valid ##1
      engine_idle);
   c_busy_write: cover property (in_wr.we && !engine_idle);
   c_apb_error: cover property (apb_req.psel && apb_req.penable &&
      apb_rsp.pslverr);

endmodule : nhs_sequencer

//--- nhs_cfg.svh
/*
 * offsets, field positions, reset values and fixed figures of the
 * neural engine host sequencer; assumes inclusion by bare name.
 */
`ifndef NHS_CFG_SVH
`define NHS_CFG_SVH

// ****************************************************************
// register offsets (byte addresses on the apb bus)
// ****************************************************************
`define NHS_OFS_COUNT 12'h000
`define NHS_OFS_BASE 12'h004
`define NHS_OFS_STATUS 12'h008
`define NHS_OFS_CYCLES 12'h00c

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define NHS_ST_IDLE 0
`define NHS_ST_REDUCE 1
`define NHS_ST_EMIT 2
`define NHS_ST_DONE_LSB 16
`define NHS_RST_COUNT 16'h0002
`define NHS_RST_BASE 16'h0000
`define NHS_RST_IDLE 1'b1
`define NHS_CMD_BASE 16'h0000
`define NHS_SCRATCH_UNIT 1024
`define NHS_KB_WORDS 512

`endif

//--- nhs_pkg.sv
/*
 * types of the neural engine host sequencer: build options and the
 * grouped carriers of its ports; assumes nhs_cfg.svh alongside.
 */
package nhs_pkg;

   typedef enum logic {NHS_CONV, NHS_BINARY} nhs_engine_e;
   typedef enum logic [2:0] {
      NHS_BLOCK_RAM, NHS_ONE_LARGE, NHS_TWO_LARGE, NHS_THREE_LARGE,
      NHS_FOUR_LARGE
   } nhs_mem_e;
   typedef enum logic {NHS_PLUS_MINUS, NHS_PLUS_ZERO} nhs_binenc_e;
   typedef enum logic [1:0] {NHS_WORD16, NHS_SIGNED8, NHS_UNSIGNED8}
      nhs_bytemode_e;
   typedef enum logic [1:0] {NHS_S_IDLE, NHS_S_REDUCE, NHS_S_EMIT}
      nhs_state_e;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } nhs_apb_req_s;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } nhs_apb_rsp_s;

   typedef struct packed {
      logic we;
      logic [15:0] addr;
      logic [15:0] data;
   } nhs_in_wr_s;

   typedef struct packed {
      logic valid;
      logic [15:0] word;
   } nhs_result_s;

endpackage : nhs_pkg

//--- nhs_host_model.sv
/*
 * host-side partner of the neural engine host sequencer: writes input
 * samples, raises the run request and collects result words.
 * assumes the sequencer on the same clock and nhs_pkg compiled first.
 */
`timescale 1ns/1ps

module nhs_host_model (
   input wire logic pclk, // system clock
   input wire logic presetn, // reset, active low
   input wire logic engine_idle, // engine ready for inputs
   input wire nhs_pkg::nhs_result_s result, // result stream
   output logic run_request, // level run request
   output nhs_pkg::nhs_in_wr_s in_wr // input memory write port
);
   import nhs_pkg::*;

   logic [15:0] got[$];

   initial begin
      run_request = 1'b0;
      in_wr = '0;
   end

   // no back-pressure exists, so every valid cycle must be taken
   always @(posedge pclk) begin
      if (presetn === 1'b1 && result.valid === 1'b1) begin
         got.push_back(result.word);
      end
   end

   // called just after an edge; force_wr breaks the idle check on purpose
   task automatic write_words(input logic [15:0] base,
      input logic [7:0] vals [4], input bit force_wr, output logic ok);
      ok = (engine_idle === 1'b1);
      if (ok || force_wr) begin
         for (int i = 0; i < 4; i++) begin
            in_wr <= '{we: 1'b1, addr: base + 16'(i),
               data: {8'h00, vals[i]}};
            @(posedge pclk);
         end
         in_wr.we <= 1'b0;
      end
   endtask : write_words

   task automatic start_run(output logic ok);
      ok = 1'b0;
      run_request <= 1'b1;
      for (int i = 0; i < 20 && !ok; i++) begin
         @(posedge pclk);
         ok = (engine_idle === 1'b0);
      end
      run_request <= 1'b0;
   endtask : start_run

endmodule : nhs_host_model

//--- nhs_sequencer_test.sv
/*
 * self-checking bench of the neural engine host sequencer in signed
 * byte mode; the host model drives inputs, the bench drives apb.
 * assumes nhs_pkg, nhs_cfg.svh and nhs_host_model alongside.
 */
`timescale 1ns/1ps
`include "nhs_cfg.svh"

module nhs_sequencer_test;
   import nhs_pkg::*;

   localparam logic [2:0] SHIFT = 3'h5;
   logic pclk;
   logic presetn;
   logic run_request;
   logic engine_idle;
   nhs_apb_req_s apb_req;
   nhs_apb_rsp_s apb_rsp;
   nhs_in_wr_s in_wr;
   nhs_result_s result;
   int errors;
   int n_compared;
   logic [7:0] vals [4] = '{8'h00, 8'h08, 8'hff, 8'h5a};
   logic [7:0] alt [4] = '{8'h77, 8'h33, 8'h01, 8'h9c};

   nhs_sequencer #(.BYTE_MODE(NHS_SIGNED8), .BYTE_SHIFT(SHIFT)) dut (
      .pclk(pclk), .presetn(presetn), .apb_req(apb_req),
      .apb_rsp(apb_rsp), .run_request(run_request),
      .engine_idle(engine_idle), .in_wr(in_wr), .result(result));

   nhs_host_model host (
      .pclk(pclk), .presetn(presetn), .engine_idle(engine_idle),
      .result(result), .run_request(run_request), .in_wr(in_wr));

   initial pclk = 1'b0;
   always #4 pclk = ~pclk;

   // ****************************************************************
   // checking and closing
   // ****************************************************************
   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude

   task automatic timeout(input string what);
      errors++;
      $display("[FAIL] %s expected response seen none", what);
      conclude();
   endtask : timeout

   // byte reduction then widening, worked out independently
   function automatic logic [15:0] expand(input logic [15:0] w);
      logic [15:0] v;
      logic [7:0] b;
      v = w >> (8 - SHIFT);
      b = w[15] ? 8'h00 : (v > 16'h00ff ? 8'hff : v[7:0]);
      return {{8{b[7]}}, b} << (8 - SHIFT);
   endfunction : expand

   // ****************************************************************
   // bus and sequence helpers
   // ****************************************************************
   task automatic apb(input logic wr, input logic [11:0] addr,
      input logic [31:0] wdata, output logic [31:0] rdata, output logic err);
      int i;
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr,
         pwdata: wdata};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge pclk);
         if (apb_rsp.pready === 1'b1) break;
      end
      if (i == 16) timeout("pready");
      rdata = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic run_and_compare(input bit poke);
      logic ok;
      int i;
      host.got.delete();
      host.start_run(ok);
      check("engine_idle fell", ok, 1'b1);
      if (poke) host.write_words(16'h0010, alt, 1'b1, ok);
      for (i = 0; i < 200; i++) begin
         @(posedge pclk);
         if (engine_idle === 1'b1) break;
      end
      if (i == 200) timeout("engine_idle");
      @(posedge pclk);
      check("result count", 32'(host.got.size()), 32'h4);
      for (i = 0; i < 4 && i < host.got.size(); i++) begin
         check("word", host.got[i], expand({8'h00, vals[i]}));
      end
   endtask : run_and_compare

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic s_reset_values;
      logic [31:0] rd;
      logic err;
      check("idle", engine_idle, 1'b1);
      check("result", result, '0);
      check("apb answer", {apb_rsp.prdata, apb_rsp.pslverr}, '0);
      apb(1'b0, `NHS_OFS_COUNT, 32'h0, rd, err);
      check("count reset", rd, 32'(`NHS_RST_COUNT));
      apb(1'b0, `NHS_OFS_STATUS, 32'h0, rd, err);
      check("status reset", rd & 32'hffff0007, 32'h1);
      apb(1'b1, 12'h010, 32'h5, rd, err);
      check("unmapped error", err, 1'b1);
   endtask : s_reset_values

   task automatic s_run;
      logic [31:0] rd;
      logic err;
      logic ok;
      apb(1'b1, `NHS_OFS_COUNT, 32'h4, rd, err);
      apb(1'b1, `NHS_OFS_BASE, 32'h10, rd, err);
      apb(1'b0, `NHS_OFS_BASE, 32'h0, rd, err);
      check("base readback", rd, 32'h10);
      host.write_words(16'h0010, vals, 1'b0, ok);
      run_and_compare(1'b0);
      apb(1'b0, `NHS_OFS_STATUS, 32'h0, rd, err);
      check("status after run", rd & 32'hffff0007, 32'h40001);
   endtask : s_run

   // overwrites while busy must be dropped, so a rerun repeats the results
   task automatic s_busy_write;
      run_and_compare(1'b1);
   endtask : s_busy_write

   task automatic s_short_reset;
      logic [31:0] rd;
      logic err;
      logic ok;
      host.start_run(ok);
      presetn <= 1'b0;
      @(posedge pclk);
      check("idle in reset", engine_idle, 1'b1);
      check("result in reset", result, '0);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, `NHS_OFS_COUNT, 32'h0, rd, err);
      check("count after pulse", rd, 32'(`NHS_RST_COUNT));
   endtask : s_short_reset

   initial begin
      presetn = 1'b0;
      apb_req = '0;
      errors = 0;
      n_compared = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      s_reset_values();
      s_run();
      s_busy_write();
      s_short_reset();
      conclude();
   end

endmodule : nhs_sequencer_test
